/* File: src/brd_decode.sv */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RULE1] opcodes 20-23: always/never/higher/lower-same, 2B 3cyc
// [RULE2] higher-same and lower aliases of 24, 25
// [RULE3] 24/25 carry, 26/27 zero, 2B 3cyc
// [RULE4] 28/29 half carry, 2A/2B sign
// [RULE5] 2C mask clear, 2D mask set
// [RULE6] 2E irq pin low, 2F high
// [RULE7] bit test branch-if-set 2n, 3B 5cyc
// [RULE8] branch-if-clear 01+2n, set/clear bit 2B 5cyc
// [RULE9] test operand: memory forms one cycle less
// [RULE10] 9A clears interrupt mask, 1B 2cyc
// [RULE11] 9B sets interrupt mask, 1B 2cyc
// [RULE12] rmw: 3 inherent, 5 direct/indexed, 6 offset
// [RULE13] control 2cyc; trap 10, rts 6, rti 9
// [RULE14] multiply A*X to A:X, clear H and C
module brd_decode
	import brd_pkg::*;
(
	input wire logic MCLK_IN, // core clock
	input wire logic RST_B_IN, // async reset, low
	input wire logic [AXI_AW-1:0] S_AXI_AWADDR_IN, // write address
	input wire logic S_AXI_AWVALID_IN, // write address valid
	output logic S_AXI_AWREADY_OUT, // write address ready
	input wire logic [31:0] S_AXI_WDATA_IN, // write data
	input wire logic [3:0] S_AXI_WSTRB_IN, // byte strobes
	input wire logic S_AXI_WVALID_IN, // write data valid
	output logic S_AXI_WREADY_OUT, // write data ready
	output logic [1:0] S_AXI_BRESP_OUT, // write response
	output logic S_AXI_BVALID_OUT, // write response valid
	input wire logic S_AXI_BREADY_IN, // write response ready
	input wire logic [AXI_AW-1:0] S_AXI_ARADDR_IN, // read address
	input wire logic S_AXI_ARVALID_IN, // read address valid
	output logic S_AXI_ARREADY_OUT, // read address ready
	output logic [31:0] S_AXI_RDATA_OUT, // read data
	output logic [1:0] S_AXI_RRESP_OUT, // read response
	output logic S_AXI_RVALID_OUT, // read data valid
	input wire logic S_AXI_RREADY_IN, // read data ready
	input wire logic [7:0] OPCODE_IN, // fetched opcode
	input wire logic OPCODE_VALID_IN, // opcode offered
	output logic OPCODE_READY_OUT, // decoder free
	input wire brd_ccr_t FLAGS_IN, // condition codes
	input wire logic IRQ_PIN_IN, // external interrupt level
	input wire logic [7:0] OPERAND_IN, // tested memory byte
	input wire logic [7:0] ACC_IN, // accumulator
	input wire logic [7:0] IDX_IN, // index register
	output logic BUSY_OUT, // sequencing bus cycles
	output logic DONE_OUT, // instruction finished pulse
	output logic [1:0] INSN_LEN_OUT, // bytes of instruction
	output logic [3:0] INSN_CYCLES_OUT, // cycles of instruction
	output logic BRANCH_TAKEN_OUT, // branch decision
	output logic ILLEGAL_OUT, // opcode outside group
	output logic MASK_SET_OUT, // set interrupt mask pulse
	output logic MASK_CLEAR_OUT, // clear interrupt mask pulse
	output logic CLEAR_HC_OUT, // clear half carry and carry
	output logic [15:0] PRODUCT_OUT // A:X after multiply
);

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	// columns of the single-operand group
	function automatic logic rmw_col(input logic [3:0] lo);
		return lo inside {4'h0, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9,
			4'hA, 4'hC, 4'hD, 4'hF};
	endfunction

	// class, length and cycle count of one opcode
	function automatic brd_dec_t decode(input logic [7:0] op);
		brd_dec_t d;
		logic inh;
		d = '{1'h0, K_NONE, LEN_1, CYC_ILLEGAL};
		inh = op[7:4] == RMW_ACC_HI || op[7:4] == RMW_IDX_HI;
		if (op[7:4] == BTB_HI) begin
			d = '{1'h1, K_BTB, LEN_3, CYC_BIT}; // RULE7 RULE8
		end else if (op[7:4] == BSC_HI) begin
			d = '{1'h1, K_BSC, LEN_2, CYC_BIT}; // RULE8
		end else if (op[7:4] == BR_HI) begin
			d = '{1'h1, K_BRANCH, LEN_2, CYC_BR}; // RULE1 RULE3 RULE4
		end else if (op == BRANCH_SUBROUTINE_OP) begin
			d = '{1'h1, K_BRANCH, LEN_2, CYC_BSR}; // RULE13
		end else if (op == MULTIPLY_OP) begin
			d = '{1'h1, K_MUL, LEN_1, CYC_MUL}; // RULE13
		end else if (op[7:4] >= RMW_DIR_HI && op[7:4] <= RMW_IX_HI &&
			rmw_col(op[3:0])) begin
			d.known = 1'h1;
			d.kind = K_RMW;
			d.len = (op[7:4] == RMW_DIR_HI || op[7:4] == RMW_IX1_HI) ?
				LEN_2 : LEN_1;
			d.cyc = inh ? CYC_RMW_INH : // RULE12
				(op[7:4] == RMW_IX1_HI ? CYC_RMW_IX1 : CYC_RMW_DIR);
			if (op[3:0] == TEST_NIB && !inh) begin
				d.cyc = d.cyc - 4'h1; // RULE9
			end
		end else begin
			case (op)
				XFER_A_X_OP, XFER_X_A_OP, SET_CARRY_OP, CLEAR_CARRY_OP,
				MASK_INTERRUPTS_OP, UNMASK_INTERRUPTS_OP, STACK_RESET_OP,
				IDLE_OP, HALT_OP, WAIT_IRQ_OP: begin
					d = '{1'h1, K_CTRL, LEN_1, CYC_CTRL}; // RULE10 RULE11
				end
				SOFTWARE_TRAP_OP: d = '{1'h1, K_CTRL, LEN_1, CYC_SWI}; // RULE13
				SUB_RETURN_OP: d = '{1'h1, K_CTRL, LEN_1, CYC_RTS}; // RULE13
				INTERRUPT_RETURN_OP: begin
					d = '{1'h1, K_CTRL, LEN_1, CYC_RTI}; // RULE13
				end
				default: d = d; // not in this group
			endcase
		end
		return d;
	endfunction

	// relative branch condition; odd opcodes invert the even test
	function automatic logic br_cond(input logic [7:0] op,
		input brd_ccr_t f, input logic irq);
		logic base;
		unique case (op[3:1])
			3'h0: base = 1'h1; // always / never
			3'h1: base = !(f.c || f.z); // higher / lower-same
			3'h2: base = !f.c; // carry clear / set, aliases RULE2 RULE3
			3'h3: base = !f.z; // not equal / equal RULE3
			3'h4: base = !f.h; // half carry RULE4
			3'h5: base = !f.n; // plus / minus RULE4
			3'h6: base = !f.i; // mask clear / set RULE5
			3'h7: base = !irq; // pin low / high, level direct RULE6
		endcase
		return base ^ op[0]; // RULE1
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	brd_st_t st; // sequencer state
	logic [3:0] cnt; // cycles left
	logic [7:0] op_q; // opcode in progress
	logic hw_en; // opcodes come from the core port
	logic [7:0] aw_q; // held write address
	logic [31:0] wd_q; // held write data
	logic [3:0] ws_q; // held strobes

	// ----------------------------------------------------------------
	// decode and selection
	// ----------------------------------------------------------------
	wire wr_fire = !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT &&
		!S_AXI_BVALID_OUT; // both halves held, no answer pending
	wire [7:0] aw_al = {aw_q[7:2], 2'h0}; // aligned write word
	wire [7:0] ar_al = {S_AXI_ARADDR_IN[7:2], 2'h0}; // aligned read
	wire wr_map = aw_al inside {REG_OPCODE, REG_STATUS, REG_PRODUCT,
		REG_CTRL};
	wire rd_map = ar_al inside {REG_OPCODE, REG_STATUS, REG_PRODUCT,
		REG_CTRL};
	wire sw_op = wr_fire && aw_al == REG_OPCODE && ws_q[0];
	wire ctrl_wr = wr_fire && aw_al == REG_CTRL && ws_q[0];
	wire next_hw_en = ctrl_wr ? wd_q[0] : hw_en;
	wire busy = st == ST_RUN;
	wire go = hw_en ? (OPCODE_VALID_IN && OPCODE_READY_OUT) :
		(sw_op && !busy); // software launches only while idle
	wire [7:0] sel_op = hw_en ? OPCODE_IN : wd_q[7:0];
	brd_dec_t dec_w;
	assign dec_w = decode(sel_op);
	wire last = busy && cnt == 4'h0; // final bus cycle
	brd_st_t next_st;
	assign next_st = go ? ST_RUN : (last ? ST_IDLE : st);
	wire btb_hit = OPERAND_IN[sel_op[3:1]] ^ sel_op[0]; // RULE7 RULE8
	wire next_taken = dec_w.kind == K_BTB ? btb_hit :
		(dec_w.kind == K_BRANCH ?
		(sel_op == BRANCH_SUBROUTINE_OP ||
		br_cond(sel_op, FLAGS_IN, IRQ_PIN_IN)) : 1'h0);
	wire [31:0] status_w = {8'h00, op_q, 7'h00, ILLEGAL_OUT, BUSY_OUT,
		BRANCH_TAKEN_OUT, INSN_LEN_OUT, INSN_CYCLES_OUT};
	wire [31:0] rd_w = ar_al == REG_OPCODE ? {24'h0, op_q} :
		ar_al == REG_STATUS ? status_w :
		ar_al == REG_PRODUCT ? {16'h0, PRODUCT_OUT} :
		ar_al == REG_CTRL ? {31'h0, hw_en} : 32'h0;

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	// count the bus cycles of the launched instruction
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			st <= ST_IDLE;
			cnt <= 4'h0;
			BUSY_OUT <= 1'h0;
			OPCODE_READY_OUT <= 1'h0;
		end else begin
			st <= next_st;
			cnt <= go ? dec_w.cyc - 4'h1 : (busy ? cnt - 4'h1 : cnt);
			BUSY_OUT <= next_st == ST_RUN;
			OPCODE_READY_OUT <= next_hw_en && next_st == ST_IDLE;
		end
	end

	// latch decode results at launch
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			op_q <= 8'h00;
			INSN_LEN_OUT <= 2'h0;
			INSN_CYCLES_OUT <= 4'h0;
			BRANCH_TAKEN_OUT <= 1'h0;
			ILLEGAL_OUT <= 1'h0;
			PRODUCT_OUT <= 16'h0000;
		end else if (go) begin
			op_q <= sel_op;
			INSN_LEN_OUT <= dec_w.len;
			INSN_CYCLES_OUT <= dec_w.cyc;
			BRANCH_TAKEN_OUT <= next_taken;
			ILLEGAL_OUT <= !dec_w.known;
			if (dec_w.kind == K_MUL) begin
				PRODUCT_OUT <= 16'(ACC_IN) * 16'(IDX_IN); // RULE14
			end
		end
	end

	// flag effects land with the finishing pulse
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			DONE_OUT <= 1'h0;
			MASK_SET_OUT <= 1'h0;
			MASK_CLEAR_OUT <= 1'h0;
			CLEAR_HC_OUT <= 1'h0;
		end else begin
			DONE_OUT <= last;
			MASK_SET_OUT <= last && op_q == MASK_INTERRUPTS_OP; // RULE11
			MASK_CLEAR_OUT <= last && op_q == UNMASK_INTERRUPTS_OP; // RULE10
			CLEAR_HC_OUT <= last && op_q == MULTIPLY_OP; // RULE14
		end
	end

	// ----------------------------------------------------------------
	// bus slave, write side
	// ----------------------------------------------------------------
	// hold address and data, answer once both are in
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			S_AXI_AWREADY_OUT <= 1'h1;
			S_AXI_WREADY_OUT <= 1'h1;
			S_AXI_BVALID_OUT <= 1'h0;
			S_AXI_BRESP_OUT <= RESP_OKAY;
			aw_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			hw_en <= CTRL_RST;
		end else begin
			hw_en <= next_hw_en;
			if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
				aw_q <= S_AXI_AWADDR_IN;
				S_AXI_AWREADY_OUT <= 1'h0;
			end
			if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
				wd_q <= S_AXI_WDATA_IN;
				ws_q <= S_AXI_WSTRB_IN;
				S_AXI_WREADY_OUT <= 1'h0;
			end
			if (wr_fire) begin
				S_AXI_BVALID_OUT <= 1'h1;
				S_AXI_BRESP_OUT <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'h0;
				S_AXI_AWREADY_OUT <= 1'h1;
				S_AXI_WREADY_OUT <= 1'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// bus slave, read side
	// ----------------------------------------------------------------
	// one read at a time, data one edge after the address
	always_ff @(posedge MCLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			S_AXI_ARREADY_OUT <= 1'h1;
			S_AXI_RVALID_OUT <= 1'h0;
			S_AXI_RDATA_OUT <= 32'h0;
			S_AXI_RRESP_OUT <= RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
			S_AXI_ARREADY_OUT <= 1'h0;
			S_AXI_RVALID_OUT <= 1'h1;
			S_AXI_RDATA_OUT <= rd_w;
			S_AXI_RRESP_OUT <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
			S_AXI_RVALID_OUT <= 1'h0;
			S_AXI_ARREADY_OUT <= 1'h1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RST_B_IN);

	AST_BR_TIME: assert property (go && sel_op[7:4] == BR_HI |=> // RULE1
		INSN_LEN_OUT == LEN_2 && INSN_CYCLES_OUT == CYC_BR ##0
		BUSY_OUT [*3] ##1 DONE_OUT && !BUSY_OUT)
		else $error("branch length or timing wrong");
	AST_ALIAS: assert property (go && sel_op == BRANCH_LOWER_ALIAS |=> // RULE2
		BRANCH_TAKEN_OUT == $past(FLAGS_IN.c))
		else $error("lower alias not on carry set");
	AST_ZERO: assert property (go && sel_op == BRANCH_EQUAL_OP |=> // RULE3
		BRANCH_TAKEN_OUT == $past(FLAGS_IN.z))
		else $error("equal branch not on zero");
	AST_SIGN: assert property (go && sel_op == BRANCH_MINUS_OP |=> // RULE4
		BRANCH_TAKEN_OUT == $past(FLAGS_IN.n))
		else $error("minus branch not on sign");
	AST_MASK_BR: assert property (go && sel_op == BRANCH_MASK_SET_OP // RULE5
		|=> BRANCH_TAKEN_OUT == $past(FLAGS_IN.i))
		else $error("mask branch wrong");
	AST_IRQ: assert property (go && sel_op == BRANCH_IRQ_LOW_OP |=> // RULE6
		BRANCH_TAKEN_OUT != $past(IRQ_PIN_IN))
		else $error("irq low branch wrong");
	AST_BTB: assert property (go && sel_op[7:4] == BTB_HI |=> // RULE7
		INSN_LEN_OUT == LEN_3 ##0 BUSY_OUT [*5] ##1 DONE_OUT)
		else $error("bit test branch timing wrong");
	AST_BSC: assert property (go && sel_op[7:4] == BSC_HI |=> // RULE8
		INSN_LEN_OUT == LEN_2 && INSN_CYCLES_OUT == CYC_BIT)
		else $error("bit set/clear form wrong");
	AST_TST: assert property (go && sel_op == TEST_OPERAND_DIR_OP |=> // RULE9
		INSN_CYCLES_OUT == CYC_RMW_DIR - 4'h1 && INSN_LEN_OUT == LEN_2)
		else $error("direct test cycles wrong");
	AST_CLI: assert property (go && sel_op == UNMASK_INTERRUPTS_OP |=> // RULE10
		BUSY_OUT [*2] ##1 MASK_CLEAR_OUT && !MASK_SET_OUT)
		else $error("mask clear timing wrong");
	AST_SEI: assert property (go && sel_op == MASK_INTERRUPTS_OP |=> // RULE11
		BUSY_OUT [*2] ##1 MASK_SET_OUT && !MASK_CLEAR_OUT)
		else $error("mask set timing wrong");
	AST_IX1: assert property (go && dec_w.kind == K_RMW && // RULE12
		sel_op[7:4] == RMW_IX1_HI && sel_op[3:0] != TEST_NIB |=>
		INSN_CYCLES_OUT == CYC_RMW_IX1)
		else $error("offset rmw cycles wrong");
	AST_SWI: assert property (go && sel_op == SOFTWARE_TRAP_OP |=> // RULE13
		INSN_CYCLES_OUT == CYC_SWI ##9 BUSY_OUT ##1 !BUSY_OUT)
		else $error("trap timing wrong");
	AST_MUL: assert property (go && sel_op == MULTIPLY_OP |=> // RULE14
		PRODUCT_OUT == $past(16'(ACC_IN) * 16'(IDX_IN)) ##11
		CLEAR_HC_OUT) else $error("multiply result or flags wrong");

	COV_BRA: cover property (go && sel_op == BRANCH_ALWAYS_OP);
	COV_MUL: cover property (CLEAR_HC_OUT);
	COV_WR: cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
	COV_ILL: cover property (go && !dec_w.known);

endmodule
`default_nettype wire

/* File: src/brd_pkg.sv */
package brd_pkg;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic h; // half carry
		logic i; // interrupt mask
		logic n; // sign
		logic z; // zero
		logic c; // carry
	} brd_ccr_t;

	typedef enum logic [2:0] {
		K_NONE, K_BRANCH, K_BTB, K_BSC, K_RMW, K_MUL, K_CTRL
	} brd_kind_t;

	typedef struct packed {
		logic known; // opcode belongs to this group
		brd_kind_t kind; // instruction class
		logic [1:0] len; // bytes
		logic [3:0] cyc; // bus cycles
	} brd_dec_t;

	typedef enum logic {ST_IDLE, ST_RUN} brd_st_t;

	// ----------------------------------------------------------------
	// opcodes and opcode fields
	// ----------------------------------------------------------------
	localparam logic [3:0] BTB_HI = 4'h0; // bit test and branch row
	localparam logic [3:0] BSC_HI = 4'h1; // bit set/clear row
	localparam logic [3:0] BR_HI = 4'h2; // relative branch row
	localparam logic [3:0] RMW_DIR_HI = 4'h3;
	localparam logic [3:0] RMW_ACC_HI = 4'h4;
	localparam logic [3:0] RMW_IDX_HI = 4'h5;
	localparam logic [3:0] RMW_IX1_HI = 4'h6;
	localparam logic [3:0] RMW_IX_HI = 4'h7;
	localparam logic [3:0] TEST_NIB = 4'hD; // test operand column
	localparam logic [7:0] BRANCH_ALWAYS_OP = 8'h20;
	localparam logic [7:0] BRANCH_CARRY_CLEAR_OP = 8'h24;
	localparam logic [7:0] BRANCH_HIGHER_SAME_ALIAS = 8'h24;
	localparam logic [7:0] BRANCH_LOWER_ALIAS = 8'h25;
	localparam logic [7:0] BRANCH_EQUAL_OP = 8'h27;
	localparam logic [7:0] BRANCH_MINUS_OP = 8'h2B;
	localparam logic [7:0] BRANCH_MASK_SET_OP = 8'h2D;
	localparam logic [7:0] BRANCH_IRQ_LOW_OP = 8'h2E;
	localparam logic [7:0] BRANCH_SUBROUTINE_OP = 8'hAD;
	localparam logic [7:0] TEST_OPERAND_DIR_OP = 8'h3D;
	localparam logic [7:0] MULTIPLY_OP = 8'h42;
	localparam logic [7:0] UNMASK_INTERRUPTS_OP = 8'h9A;
	localparam logic [7:0] MASK_INTERRUPTS_OP = 8'h9B;
	localparam logic [7:0] SOFTWARE_TRAP_OP = 8'h83;
	localparam logic [7:0] SUB_RETURN_OP = 8'h81;
	localparam logic [7:0] INTERRUPT_RETURN_OP = 8'h80;
	localparam logic [7:0] XFER_A_X_OP = 8'h97;
	localparam logic [7:0] XFER_X_A_OP = 8'h9F;
	localparam logic [7:0] SET_CARRY_OP = 8'h99;
	localparam logic [7:0] CLEAR_CARRY_OP = 8'h98;
	localparam logic [7:0] STACK_RESET_OP = 8'h9C;
	localparam logic [7:0] IDLE_OP = 8'h9D;
	localparam logic [7:0] HALT_OP = 8'h8E;
	localparam logic [7:0] WAIT_IRQ_OP = 8'h8F;

	// ----------------------------------------------------------------
	// lengths and cycle counts
	// ----------------------------------------------------------------
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	localparam logic [3:0] CYC_BR = 4'h3;
	localparam logic [3:0] CYC_BSR = 4'h6;
	localparam logic [3:0] CYC_BIT = 4'h5;
	localparam logic [3:0] CYC_RMW_INH = 4'h3;
	localparam logic [3:0] CYC_RMW_DIR = 4'h5;
	localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
	localparam logic [3:0] CYC_MUL = 4'hB;
	localparam logic [3:0] CYC_CTRL = 4'h2;
	localparam logic [3:0] CYC_SWI = 4'hA;
	localparam logic [3:0] CYC_RTS = 4'h6;
	localparam logic [3:0] CYC_RTI = 4'h9;
	localparam logic [3:0] CYC_ILLEGAL = 4'h1;

	// ----------------------------------------------------------------
	// register map and bus answers
	// ----------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0] REG_OPCODE = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PRODUCT = 8'h08;
	localparam logic [7:0] REG_CTRL = 8'h0C;
	localparam logic CTRL_RST = 1'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: verif/brd_decode_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module brd_decode_tb;
	import brd_pkg::*;
	logic mclk = 1'b0; // core clock
	logic rst_b = 1'b0; // reset, low
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [7:0] opcode, operand, acc = 8'h00, idx = 8'h00;
	logic op_valid, op_ready, irq = 1'b0;
	brd_ccr_t flags = 5'h00;
	logic busy, done, taken, ill, mset, mclr, chc;
	logic [1:0] len;
	logic [3:0] cyc;
	logic [15:0] product;
	int mismatches = 0, n_checks = 0;

	always #2 mclk = ~mclk;

	brd_decode brd_decode_i (.MCLK_IN(mclk), .RST_B_IN(rst_b),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
		.S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
		.S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
		.S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
		.S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
		.S_AXI_RREADY_IN(rready), .OPCODE_IN(opcode),
		.OPCODE_VALID_IN(op_valid), .OPCODE_READY_OUT(op_ready),
		.FLAGS_IN(flags), .IRQ_PIN_IN(irq), .OPERAND_IN(operand),
		.ACC_IN(acc), .IDX_IN(idx), .BUSY_OUT(busy), .DONE_OUT(done),
		.INSN_LEN_OUT(len), .INSN_CYCLES_OUT(cyc),
		.BRANCH_TAKEN_OUT(taken), .ILLEGAL_OUT(ill),
		.MASK_SET_OUT(mset), .MASK_CLEAR_OUT(mclr),
		.CLEAR_HC_OUT(chc), .PRODUCT_OUT(product));

	brd_mem_model brd_mem_model_i (.clk_in(mclk), .ready_in(op_ready),
		.opcode_out(opcode), .valid_out(op_valid),
		.operand_out(operand));

	// ----------------------------------------------------------------
	// bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// expected decode of one opcode, worked out from the opcode map
	task automatic exp_of(input logic [7:0] op, input logic [7:0] m,
		output logic e_ill, output logic [1:0] e_len,
		output logic [3:0] e_cyc, output logic e_tk, output logic has_tk);
		logic [3:0] hi, lo;
		logic c;
		hi = op[7:4];
		lo = op[3:0];
		e_ill = 1'b0;
		e_len = 2'h1;
		e_cyc = 4'h2;
		e_tk = 1'b1;
		has_tk = 1'b0;
		c = 1'b1;
		if (hi == 4'h0) begin // bit test and branch
			e_len = 2'h3;
			e_cyc = 4'h5;
			has_tk = 1'b1;
			e_tk = m[lo[3:1]] ^ lo[0];
		end else if (hi == 4'h1) begin // bit set and clear
			e_len = 2'h2;
			e_cyc = 4'h5;
		end else if (hi == 4'h2) begin // relative branches
			case (lo[3:1])
				3'h1: c = ~(flags.c | flags.z);
				3'h2: c = ~flags.c;
				3'h3: c = ~flags.z;
				3'h4: c = ~flags.h;
				3'h5: c = ~flags.n;
				3'h6: c = ~flags.i;
				3'h7: c = ~irq;
				default: c = 1'b1;
			endcase
			e_len = 2'h2;
			e_cyc = 4'h3;
			has_tk = 1'b1;
			e_tk = c ^ lo[0];
		end else if (op == 8'h42) begin
			e_cyc = 4'hB;
		end else if (hi inside {[4'h3:4'h7]} &&
			lo inside {4'h0, 4'h3, 4'h4, [4'h6:4'hA], 4'hC, 4'hD, 4'hF}) begin
			e_len = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
			e_cyc = (hi inside {4'h4, 4'h5}) ? 4'h3 :
				((hi == 4'h6) ? 4'h6 : 4'h5);
			if (lo == 4'hD && !(hi inside {4'h4, 4'h5})) e_cyc = e_cyc - 4'h1;
		end else if (op == 8'hAD) begin // subroutine branch
			e_len = 2'h2;
			e_cyc = 4'h6;
			has_tk = 1'b1;
		end else if (op == 8'h83) e_cyc = 4'hA;
		else if (op == 8'h81) e_cyc = 4'h6;
		else if (op == 8'h80) e_cyc = 4'h9;
		else if (!(op inside {8'h97, 8'h9F, 8'h98, 8'h99, 8'h9A, 8'h9B,
			8'h9C, 8'h9D, 8'h8E, 8'h8F})) begin
			e_ill = 1'b1;
			e_cyc = 4'h1;
		end
	endtask

	task automatic give_verdict();
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		#200000;
		mismatches++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic e_ill, e_tk, has_tk;
		logic [1:0] e_len;
		logic [3:0] e_cyc;
		logic [7:0] m;
		int n, g;
		repeat (20) @(posedge mclk);
		rst_b <= 1'b1;
		// software mode: multiply launched over the bus
		acc <= 8'hF3;
		idx <= 8'h2D;
		axi_rd(8'h0C, d, r);
		chk("ctrl reset", d, 32'h0);
		chk("port closed", {31'h0, op_ready}, 32'h0);
		axi_wr(8'h00, 32'h42, r);
		g = 0;
		while (done !== 1'b1 && g < 40) begin
			@(posedge mclk);
			#1;
			g++;
		end
		chk("sw done", 32'(done), 32'h1);
		axi_rd(8'h04, d, r);
		chk("status", d & 32'h00FF01BF, 32'h0042001B);
		axi_rd(8'h08, d, r);
		chk("product", d, 32'h00002AB7);
		axi_rd(8'h10, d, r);
		chk("unmapped rdata", d, 32'h0);
		chk("unmapped rresp", 32'(r), 32'h2);
		axi_wr(8'h14, 32'h1, r);
		chk("unmapped bresp", 32'(r), 32'h2);
		axi_wr(8'h0C, 32'h1, r);
		chk("ctrl bresp", 32'(r), 32'h0);
		axi_rd(8'h0C, d, r);
		chk("ctrl", d, 32'h1);
		// hardware mode: every opcode under two flag settings
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			flags <= p ? 5'h1F : 5'h00;
			irq <= p[0];
			acc <= p ? 8'hFF : 8'h3C;
			idx <= p ? 8'hFF : 8'h81;
			m = p ? 8'h5A : 8'hA5;
			for (int o = 0; o < 256; o++) begin
				@(posedge mclk);
				exp_of(o[7:0], m, e_ill, e_len, e_cyc, e_tk, has_tk);
				brd_mem_model_i.issue(o[7:0], m);
				#1;
				chk("illegal", 32'(ill), 32'(e_ill));
				if (!e_ill) chk("length", 32'(len),
					32'(e_len));
				chk("cycles", 32'(cyc),
					32'(e_cyc));
				if (has_tk) chk("taken", 32'(taken),
					32'(e_tk));
				n = 0;
				g = 0;
				while (done !== 1'b1 && g < 20) begin
					if (busy === 1'b1) n++;
					g++;
					@(posedge mclk);
					#1;
				end
				chk("done", 32'(done), 32'h1);
				chk("busy span", n, 32'(e_cyc));
				chk("pulses", 32'({mset, mclr, chc}),
					32'({o == 8'h9B, o == 8'h9A, o == 8'h42}));
				if (o == 8'h42) chk("mul", 32'(product),
					32'(16'(acc) * 16'(idx)));
			end
		end
		give_verdict();
	end
endmodule
`default_nettype wire

/* File: verif/brd_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// memory side: offers one opcode and its operand byte per fetch
// ----------------------------------------------------------------
module brd_mem_model
	import brd_pkg::*;
(
	input wire logic clk_in, // core clock
	input wire logic ready_in, // decoder free
	output logic [7:0] opcode_out, // fetched opcode
	output logic valid_out, // opcode offered
	output logic [7:0] operand_out // tested memory byte
);
	initial begin
		opcode_out = 8'h00;
		valid_out = 1'b0;
		operand_out = 8'h00;
	end

	// hold the offer until the decoder takes it, then scramble the bus
	task automatic issue(input logic [7:0] op, input logic [7:0] m);
		@(posedge clk_in);
		opcode_out <= op;
		operand_out <= m;
		valid_out <= 1'b1;
		do @(posedge clk_in); while (ready_in !== 1'b1);
		valid_out <= 1'b0;
		opcode_out <= ~op; // released bus shows no stale opcode
		operand_out <= ~m;
	endtask
endmodule
`default_nettype wire
